// [rtl/plld_pkg.sv]
// shared constants for the pll lock detector and calibration status bank
package plld_pkg;

    // ************************************************************
    // register port geometry and register indexes
    // ************************************************************
    localparam int unsigned ADDR_W = 3;                     // register index width
    localparam int unsigned DATA_W = 16;                    // register data width
    localparam logic [2:0]  IDX_THIRD_POLE   = 3'h0;        // loop_filter_third_pole
    localparam logic [2:0]  IDX_LOCK_CFG     = 3'h1;        // lock_detector_config
    localparam logic [2:0]  IDX_LOCK_THR     = 3'h2;        // lock_threshold_config
    localparam logic [2:0]  IDX_CAL_STATUS   = 3'h3;        // oscillator_cal_status
    localparam logic [2:0]  IDX_LOCK_STATUS  = 3'h4;        // real-time lock status

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int unsigned TP_BYPASS_BIT    = 7;           // third_pole_bypass
    localparam int unsigned TP_RES_LSB       = 4;           // pole3_resistor_sel [6:4]
    localparam int unsigned TP_CAP_LSB       = 0;           // pole3_cap_sel [2:0]
    localparam int unsigned LC_RAW_SEL_BIT   = 9;           // raw lock to pin
    localparam int unsigned LC_FINE_EN_BIT   = 8;           // precision detector enable
    localparam int unsigned LC_TIMER_LSB     = 6;           // debounce code [7:6]
    localparam int unsigned LC_ONCE_BIT      = 5;           // lock_latch_once
    localparam int unsigned LC_CAL_BYP_BIT   = 4;           // detect during calibration
    localparam int unsigned LC_DISABLE_BIT   = 3;           // detector off, lock forced
    localparam int unsigned LC_FILT_LSB      = 0;           // filter resistor code [2:0]
    localparam int unsigned TH_HIGH_LSB      = 4;           // fine_lock_high_thr [7:4]
    localparam int unsigned TH_LOW_LSB       = 0;           // fine_lock_low_thr [3:0]
    localparam int unsigned CS_FAIL_BIT      = 7;           // calibration failed
    localparam int unsigned CS_DONE_BIT      = 6;           // calibration done
    localparam int unsigned CS_BAND_LSB      = 0;           // band [5:0]

    // ************************************************************
    // values after reset
    // ************************************************************
    localparam logic       RST_TP_BYPASS     = 1'h0;
    localparam logic [2:0] RST_TP_RES        = 3'h3;
    localparam logic [2:0] RST_TP_CAP        = 3'h7;
    localparam logic       RST_RAW_SEL       = 1'h0;
    localparam logic       RST_FINE_EN       = 1'h1;
    localparam logic [1:0] RST_TIMER         = 2'h2;
    localparam logic       RST_ONCE          = 1'h0;
    localparam logic       RST_CAL_BYP       = 1'h0;
    localparam logic       RST_DISABLE       = 1'h0;
    localparam logic [2:0] RST_FILT          = 3'h0;
    localparam logic [3:0] RST_THR_HIGH      = 4'h8;
    localparam logic [3:0] RST_THR_LOW       = 4'h8;

    // ************************************************************
    // debounce intervals in system clock cycles
    // ************************************************************
    localparam logic [1:0]  TIMER_NONE       = 2'h0;        // no debounce
    localparam logic [1:0]  TIMER_SHORT      = 2'h1;
    localparam logic [1:0]  TIMER_MID        = 2'h2;
    localparam logic [1:0]  TIMER_LONG       = 2'h3;
    localparam logic [15:0] DEB_SHORT_CYCLES = 16'h023A;    // shortest interval, 570 cycles

    typedef logic [15:0] plld_count_type;                   // debounce counter
endpackage

// [rtl/plld_lock_cal_regs.sv]
// pll lock detector, calibration status and loop filter register bank
// Function
// - debounce codes 0,570,5700,57000 cycles
// - one-time mode holds lock once asserted
// - detector waits for calibration unless bypassed
// - disable bit forces lock asserted
// - raw select drives pin undebounced
// - precision enable picks fine detector, thresholds
// - done bit reads calibration completion
// - fail bit reads calibration failure
// - six-bit band field read-only
// - two four-bit thresholds, reset eight
// - third-pole resistor and capacitor codes forwarded
// - three-bit lock filter resistor code
// - status bit shows resulting lock
`timescale 1ns/10ps
`default_nettype none
module plld_lock_cal_regs
    import plld_pkg::*;
#(
    parameter plld_count_type DEB_MID_CYCLES  = 16'h1644,  // debounce code 2, 5700 cycles
    parameter plld_count_type DEB_LONG_CYCLES = 16'hDEA8   // debounce code 3, 57000 cycles
)
(
    input  wire logic                    MCLK,               // 10 MHz system clock
    input  wire logic                    RST,                // async reset, high
    input  wire logic                    CE,                 // clock enable
    input  wire logic                    REG_WR,             // register write strobe
    input  wire logic                    REG_RD,             // register read strobe
    input  wire logic [plld_pkg::ADDR_W-1:0] REG_ADDR,       // register index
    input  wire logic [plld_pkg::DATA_W-1:0] REG_WDATA,      // write data
    output logic      [plld_pkg::DATA_W-1:0] REG_RDATA,      // read data
    input  wire logic                    FINE_LOCK_RAW,      // precision detector lock
    input  wire logic                    BASIC_LOCK_RAW,     // original detector lock
    input  wire logic                    CAL_DONE_IN,        // calibration finished
    input  wire logic                    CAL_FAIL_IN,        // calibration failed
    input  wire logic [5:0]              CAL_BAND_IN,        // chosen oscillator band
    output logic                         LOCK_PIN,           // lock status pin
    output logic                         FINE_LOCK_EN,       // precision detector on
    output logic [3:0]                   FINE_LOCK_HIGH_THR, // high threshold code
    output logic [3:0]                   FINE_LOCK_LOW_THR,  // low threshold code
    output logic [2:0]                   LOCK_FILT_RES_SEL,  // lock filter resistor
    output logic                         THIRD_POLE_BYPASS,  // third pole bypassed
    output logic [2:0]                   POLE3_RESISTOR_SEL, // third pole resistor
    output logic [2:0]                   POLE3_CAP_SEL       // third pole capacitor
);
    import plld_pkg::*;

    // ************************************************************
    // declarations
    // ************************************************************
    logic           raw_sel;          // raw lock to pin
    logic [1:0]     timer_code;       // debounce code
    logic           lock_latch_once;  // one-time lock mode
    logic           cal_bypass;       // detect during calibration
    logic           det_disable;      // detector off, lock forced
    logic [8:0]     meta_q;           // first synchroniser stage
    logic [8:0]     sync_q;           // second synchroniser stage
    logic           fine_raw;         // synced precision lock
    logic           basic_raw;        // synced original lock
    logic           cal_done;         // synced done
    logic           cal_fail;         // synced fail
    logic [5:0]     cal_band;         // synced band
    logic           sel_raw;          // selected undebounced lock
    logic           gate_raw;         // raw lock gated by calibration done or bypass
    plld_count_type deb_cnt;          // debounce counter
    logic           deb_lock;         // debounced lock
    logic           held;             // one-time lock memory
    logic           lock_state;       // resulting lock
    plld_count_type next_deb_cnt;
    logic           next_deb_lock;
    logic           next_held;

    // debounce length for a timer code
    function automatic plld_count_type deb_target(input logic [1:0] code);
        plld_count_type t;
        unique case (code)
            TIMER_SHORT: t = DEB_SHORT_CYCLES;
            TIMER_MID:   t = DEB_MID_CYCLES;
            TIMER_LONG:  t = DEB_LONG_CYCLES;
            default:     t = 16'h0001;
        endcase
        return t;
    endfunction

    // ************************************************************
    // configuration registers
    // ************************************************************
    // software writes, frozen while CE is low
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            THIRD_POLE_BYPASS  <= RST_TP_BYPASS;
            POLE3_RESISTOR_SEL <= RST_TP_RES;
            POLE3_CAP_SEL      <= RST_TP_CAP;
            raw_sel            <= RST_RAW_SEL;
            FINE_LOCK_EN       <= RST_FINE_EN;
            timer_code         <= RST_TIMER;
            lock_latch_once    <= RST_ONCE;
            cal_bypass         <= RST_CAL_BYP;
            det_disable        <= RST_DISABLE;
            LOCK_FILT_RES_SEL  <= RST_FILT;
            FINE_LOCK_HIGH_THR <= RST_THR_HIGH;
            FINE_LOCK_LOW_THR  <= RST_THR_LOW;
        end
        else if (CE && REG_WR)
        begin
            unique case (REG_ADDR)
                IDX_THIRD_POLE:
                begin
                    // bypass is honoured as written; integer divider is software's duty
                    THIRD_POLE_BYPASS  <= REG_WDATA[TP_BYPASS_BIT];
                    POLE3_RESISTOR_SEL <= REG_WDATA[TP_RES_LSB +: 3];
                    POLE3_CAP_SEL      <= REG_WDATA[TP_CAP_LSB +: 3];
                end
                IDX_LOCK_CFG:
                begin
                    raw_sel           <= REG_WDATA[LC_RAW_SEL_BIT];
                    FINE_LOCK_EN      <= REG_WDATA[LC_FINE_EN_BIT];
                    timer_code        <= REG_WDATA[LC_TIMER_LSB +: 2];
                    lock_latch_once   <= REG_WDATA[LC_ONCE_BIT];
                    cal_bypass        <= REG_WDATA[LC_CAL_BYP_BIT];
                    det_disable       <= REG_WDATA[LC_DISABLE_BIT];
                    LOCK_FILT_RES_SEL <= REG_WDATA[LC_FILT_LSB +: 3];
                end
                IDX_LOCK_THR:
                begin
                    FINE_LOCK_HIGH_THR <= REG_WDATA[TH_HIGH_LSB +: 4];
                    FINE_LOCK_LOW_THR  <= REG_WDATA[TH_LOW_LSB +: 4];
                end
                default:
                begin
                    // read-only or unmapped: write ignored
                end
            endcase
        end
    end

    // ************************************************************
    // input synchronisers
    // ************************************************************
    // analog lock and calibration results are asynchronous to MCLK
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            meta_q <= 9'h000;
            sync_q <= 9'h000;
        end
        else if (CE)
        begin
            meta_q <= {CAL_BAND_IN, CAL_FAIL_IN, CAL_DONE_IN, BASIC_LOCK_RAW ^ 1'b0};
            sync_q <= meta_q;
        end
    end

    // fine lock gets its own pair below to keep the vector layout simple
    logic fine_meta;  // first stage, precision lock
    logic fine_sync;  // second stage, precision lock
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            fine_meta <= 1'b0;
            fine_sync <= 1'b0;
        end
        else if (CE)
        begin
            fine_meta <= FINE_LOCK_RAW;
            fine_sync <= fine_meta;
        end
    end

    // unpack synced inputs
    assign basic_raw = sync_q[0];
    assign cal_done  = sync_q[1];
    assign cal_fail  = sync_q[2];
    assign cal_band  = sync_q[8:3];
    assign fine_raw  = fine_sync;

    // detector choice and calibration gating
    assign sel_raw  = FINE_LOCK_EN ? fine_raw : basic_raw;
    assign gate_raw = sel_raw & (cal_bypass | cal_done);

    // ************************************************************
    // debounce and lock state
    // ************************************************************
    // count continuous raw lock; any drop restarts
    always_comb
    begin
        next_deb_cnt  = deb_cnt;
        next_deb_lock = deb_lock;
        if (!gate_raw)
        begin
            next_deb_cnt  = 16'h0000;
            next_deb_lock = 1'b0;
        end
        else if (timer_code == TIMER_NONE)
        begin
            next_deb_cnt  = 16'h0000;
            next_deb_lock = 1'b1;
        end
        else if (!deb_lock)
        begin
            if (deb_cnt == deb_target(timer_code) - 16'h0001)
            begin
                next_deb_lock = 1'b1;
            end
            else
            begin
                next_deb_cnt = deb_cnt + 16'h0001;
            end
        end
        next_held = lock_latch_once & (held | next_deb_lock);
    end

    // debounce registers
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            deb_cnt  <= 16'h0000;
            deb_lock <= 1'b0;
            held     <= 1'b0;
        end
        else if (CE)
        begin
            deb_cnt  <= next_deb_cnt;
            deb_lock <= next_deb_lock;
            held     <= next_held;
        end
    end

    // resulting lock and status pin
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            lock_state <= 1'b0;
            LOCK_PIN   <= 1'b0;
        end
        else if (CE)
        begin
            lock_state <= det_disable | next_deb_lock | next_held;
            if (raw_sel)
            begin
                LOCK_PIN <= sel_raw;
            end
            else
            begin
                LOCK_PIN <= det_disable | next_deb_lock | next_held;
            end
        end
    end

    // ************************************************************
    // register read
    // ************************************************************
    // read data registered on the read strobe, zero when unmapped
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            REG_RDATA <= 16'h0000;
        end
        else if (CE && REG_RD)
        begin
            unique case (REG_ADDR)
                IDX_THIRD_POLE:
                    REG_RDATA <= {8'h00, THIRD_POLE_BYPASS, POLE3_RESISTOR_SEL,
                                  1'b0, POLE3_CAP_SEL};
                IDX_LOCK_CFG:
                    REG_RDATA <= {6'h00, raw_sel, FINE_LOCK_EN, timer_code,
                                  lock_latch_once, cal_bypass, det_disable,
                                  LOCK_FILT_RES_SEL};
                IDX_LOCK_THR:
                    REG_RDATA <= {8'h00, FINE_LOCK_HIGH_THR, FINE_LOCK_LOW_THR};
                IDX_CAL_STATUS:
                    REG_RDATA <= {8'h00, cal_fail, cal_done, cal_band};
                IDX_LOCK_STATUS:
                    REG_RDATA <= {15'h0000, lock_state};
                default:
                    REG_RDATA <= 16'h0000;
            endcase
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking assert_clk @(posedge MCLK); endclocking
    default disable iff (RST);

    AST_DISABLE_FORCES_LOCK: assert property (
        (CE && det_disable) |=>
            (lock_state && LOCK_PIN == ($past(raw_sel) ? $past(sel_raw) : 1'b1)))
        else $error("lock not forced while detector disabled");

    AST_NO_DEBOUNCE: assert property (
        (CE && gate_raw && timer_code == 2'h0) |=> lock_state)
        else $error("code zero did not lock at once");

    AST_SHORT_COUNT: assert property (
        ($rose(deb_lock) && $past(timer_code) == 2'h1) |-> ($past(deb_cnt) == 16'h0239))
        else $error("short debounce length wrong");

    AST_DROP_RESTARTS: assert property (
        (CE && !gate_raw) |=> (deb_cnt == 16'h0000 && !deb_lock))
        else $error("raw drop did not restart debounce");

    AST_ONE_TIME_HOLDS: assert property (
        (CE && lock_latch_once && lock_state && !det_disable && !gate_raw) |=> lock_state)
        else $error("one-time lock released");

    AST_CAL_GATES: assert property (
        (CE && !cal_bypass && !cal_done && !det_disable && !lock_latch_once) |=> !lock_state)
        else $error("lock reported before calibration done");

    AST_RAW_PIN: assert property (
        (CE && raw_sel) |=> (LOCK_PIN == $past(FINE_LOCK_EN ? fine_raw : basic_raw)))
        else $error("pin not raw selected lock");

    AST_CAL_READ: assert property (
        (CE && REG_RD && REG_ADDR == 3'h3) |=>
            (REG_RDATA[7:0] == {$past(cal_fail), $past(cal_done), $past(cal_band)}))
        else $error("calibration status read wrong");

    AST_THR_WRITE: assert property (
        (CE && REG_WR && REG_ADDR == 3'h2) |=> (FINE_LOCK_HIGH_THR == $past(REG_WDATA[7:4])
            && FINE_LOCK_LOW_THR == $past(REG_WDATA[3:0])))
        else $error("threshold write lost");

    AST_STATUS_READ: assert property (
        (CE && REG_RD && REG_ADDR == 3'h4) |=> (REG_RDATA == {15'h0000, $past(lock_state)}))
        else $error("lock status read wrong");
endmodule
`default_nettype wire

// [bench/pll_lock_detect_cal_status_bench.sv]
// self-checking bench for the pll lock detector and calibration status bank
`timescale 1ns/10ps
`default_nettype none
module pll_lock_detect_cal_status_bench;
    import plld_pkg::*;
    localparam plld_count_type MID  = 16'h0014;    // shortened code 2 interval
    localparam plld_count_type LONG = 16'h0028;    // shortened code 3 interval
    logic              mclk, rst, ce, reg_wr, reg_rd;           // clock, reset, strobes
    logic              fine_raw, basic_raw, cal_done, cal_fail; // analog side inputs
    logic [5:0]        cal_band;                                // calibration band
    logic [ADDR_W-1:0] reg_addr;                                // register index
    logic [DATA_W-1:0] reg_wdata, reg_rdata, rd;                // bus data
    logic              lock_pin, fine_en, bypass;               // observed outputs
    logic [3:0]        thr_hi, thr_lo;                          // threshold outputs
    logic [2:0]        filt, p3_res, p3_cap;                    // filter codes
    int                failures, n_compared;                    // report counters
    plld_lock_cal_regs #(.DEB_MID_CYCLES(MID), .DEB_LONG_CYCLES(LONG)) uut (
        .MCLK(mclk), .RST(rst), .CE(ce), .REG_WR(reg_wr), .REG_RD(reg_rd),
        .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
        .FINE_LOCK_RAW(fine_raw), .BASIC_LOCK_RAW(basic_raw), .CAL_DONE_IN(cal_done),
        .CAL_FAIL_IN(cal_fail), .CAL_BAND_IN(cal_band), .LOCK_PIN(lock_pin),
        .FINE_LOCK_EN(fine_en), .FINE_LOCK_HIGH_THR(thr_hi), .FINE_LOCK_LOW_THR(thr_lo),
        .LOCK_FILT_RES_SEL(filt), .THIRD_POLE_BYPASS(bypass),
        .POLE3_RESISTOR_SEL(p3_res), .POLE3_CAP_SEL(p3_cap));
    // ************************************************************
    // clock, compare and bus helpers
    // ************************************************************
    initial mclk = 1'b0;
    always #50 mclk = ~mclk;
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp)
        begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            failures++;
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(negedge mclk);
        reg_wr = 1'b1; reg_addr = a; reg_wdata = d;
        @(negedge mclk);
        reg_wr = 1'b0;
    endtask
    task automatic rdr(input logic [2:0] a, output logic [15:0] d);
        @(negedge mclk);
        reg_rd = 1'b1; reg_addr = a;
        @(negedge mclk);
        reg_rd = 1'b0;
        d = reg_rdata;
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge mclk);
    endtask
    // builds a lock configuration word with filter code zero
    function automatic logic [15:0] cfg(input logic raw, input logic fine, input logic [1:0] tm,
                                        input logic once, input logic byp, input logic dis);
        return {6'h00, raw, fine, tm, once, byp, dis, 3'h0};
    endfunction
    // counts cycles from now until the pin rises and checks the span
    task automatic wait_lock(input int lo, input int hi);
        int n;
        n = 0;
        while (lock_pin !== 1'b1 && n < hi + 5)
        begin
            @(negedge mclk);
            n++;
        end
        n_compared++;
        if (n < lo || n > hi)
        begin
            $display("wrong value lock delay expected %0d..%0d seen %0d", lo, hi, n);
            failures++;
        end
    endtask
    task automatic lock_off();
        fine_raw = 1'b0; basic_raw = 1'b0;
        idle(6);
    endtask
    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_reset();
        check("third pole outputs", 16'h001F, {9'h000, bypass, p3_res, p3_cap});
        check("thresholds out", 16'h0088, {8'h00, thr_hi, thr_lo});
        check("precision enable", 16'h0001, {15'h0000, fine_en});
        check("filter res out", 16'h0000, {13'h0000, filt});
        rdr(IDX_THIRD_POLE, rd); check("third pole reg", 16'h0037, rd);
        rdr(IDX_LOCK_CFG, rd); check("lock cfg reg", 16'h0180, rd);
        rdr(IDX_LOCK_THR, rd); check("threshold reg", 16'h0088, rd);
    endtask
    task automatic t_regs();
        wr(IDX_THIRD_POLE, 16'hFFAD);
        check("third pole outputs", 16'h0055, {9'h000, bypass, p3_res, p3_cap});
        check("bypass out", 16'h0001, {15'h0000, bypass});
        rdr(IDX_THIRD_POLE, rd); check("third pole reg", 16'h00A5, rd);
        wr(IDX_LOCK_THR, 16'h0035);
        check("thresholds out", 16'h0035, {8'h00, thr_hi, thr_lo});
        rdr(IDX_LOCK_THR, rd); check("threshold reg", 16'h0035, rd);
        wr(IDX_LOCK_CFG, 16'hFD86);
        check("filter res out", 16'h0006, {13'h0000, filt});
        rdr(IDX_LOCK_CFG, rd); check("lock cfg reg", 16'h0186, rd);
        wr(IDX_CAL_STATUS, 16'h00FF);
        rdr(IDX_CAL_STATUS, rd); check("cal status after write", 16'h0000, rd);
        rdr(3'h6, rd); check("unmapped read", 16'h0000, rd);
        ce = 1'b0;
        wr(IDX_LOCK_THR, 16'h00FF);
        ce = 1'b1;
        rdr(IDX_LOCK_THR, rd); check("threshold kept", 16'h0035, rd);
    endtask
    task automatic t_cal();
        cal_fail = 1'b1; cal_band = 6'h2A;
        idle(4);
        rdr(IDX_CAL_STATUS, rd); check("cal running", 16'h00AA, rd);
        cal_done = 1'b1; cal_fail = 1'b0; cal_band = 6'h15;
        idle(4);
        rdr(IDX_CAL_STATUS, rd); check("cal done band", 16'h0055, rd);
        cal_fail = 1'b1;
        idle(4);
        rdr(IDX_CAL_STATUS, rd); check("cal failed", 16'h00D5, rd);
    endtask
    task automatic t_gate();
        cal_done = 1'b0;
        wr(IDX_LOCK_CFG, cfg(1'b0, 1'b1, TIMER_NONE, 1'b0, 1'b0, 1'b0));
        fine_raw = 1'b1;
        idle(10);
        check("pin during cal", 16'h0000, {15'h0000, lock_pin});
        cal_done = 1'b1;
        wait_lock(2, 5);
        rdr(IDX_LOCK_STATUS, rd); check("lock status", 16'h0001, rd);
        fine_raw = 1'b0;
        idle(5);
        check("real-time drop", 16'h0000, {15'h0000, lock_pin});
        rdr(IDX_LOCK_STATUS, rd); check("unlock status", 16'h0000, rd);
        cal_done = 1'b0;
        wr(IDX_LOCK_CFG, cfg(1'b0, 1'b1, TIMER_NONE, 1'b0, 1'b1, 1'b0));
        fine_raw = 1'b1;
        wait_lock(2, 4);
        lock_off();
        cal_done = 1'b1;
    endtask
    task automatic t_debounce();
        wr(IDX_LOCK_CFG, cfg(1'b0, 1'b1, TIMER_SHORT, 1'b0, 1'b0, 1'b0));
        fine_raw = 1'b1;
        idle(300);
        fine_raw = 1'b0;
        idle(2);
        fine_raw = 1'b1;
        wait_lock(570, 574);
        lock_off();
        wr(IDX_LOCK_CFG, cfg(1'b0, 1'b1, TIMER_MID, 1'b0, 1'b0, 1'b0));
        fine_raw = 1'b1;
        wait_lock(20, 24);
        lock_off();
        wr(IDX_LOCK_CFG, cfg(1'b0, 1'b1, TIMER_LONG, 1'b0, 1'b0, 1'b0));
        basic_raw = 1'b1;
        idle(50);
        check("original ignored", 16'h0000, {15'h0000, lock_pin});
        fine_raw = 1'b1;
        wait_lock(40, 44);
        lock_off();
    endtask
    task automatic t_modes();
        wr(IDX_LOCK_CFG, cfg(1'b0, 1'b1, TIMER_NONE, 1'b1, 1'b0, 1'b0));
        fine_raw = 1'b1;
        wait_lock(2, 4);
        lock_off();
        check("one-time held", 16'h0001, {15'h0000, lock_pin});
        wr(IDX_LOCK_CFG, cfg(1'b0, 1'b1, TIMER_NONE, 1'b0, 1'b0, 1'b1));
        idle(5);
        check("disabled forced", 16'h0001, {15'h0000, lock_pin});
        wr(IDX_LOCK_CFG, cfg(1'b0, 1'b1, TIMER_NONE, 1'b0, 1'b0, 1'b0));
        idle(5);
        check("real-time unlocked", 16'h0000, {15'h0000, lock_pin});
        wr(IDX_LOCK_CFG, cfg(1'b1, 1'b1, TIMER_LONG, 1'b0, 1'b0, 1'b0));
        fine_raw = 1'b1;
        wait_lock(2, 4);
        lock_off();
        wr(IDX_LOCK_CFG, cfg(1'b1, 1'b0, TIMER_LONG, 1'b0, 1'b0, 1'b0));
        check("original detector chosen", 16'h0000, {15'h0000, fine_en});
        fine_raw = 1'b1;
        idle(6);
        check("precision ignored", 16'h0000, {15'h0000, lock_pin});
        basic_raw = 1'b1;
        wait_lock(1, 4);
        lock_off();
    endtask
    // ************************************************************
    // verdict, watchdog and main sequence
    // ************************************************************
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // the scenarios need about 1,150 cycles; give up after 10,000
    initial
    begin
        #1_000_000;
        failures++;
        give_verdict();
    end
    initial
    begin
        failures = 0; n_compared = 0;
        rst = 1'b1; ce = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 3'h0;
        reg_wdata = 16'h0000; fine_raw = 1'b0; basic_raw = 1'b0; cal_done = 1'b0;
        cal_fail = 1'b0; cal_band = 6'h00;
        idle(2);
        rst = 1'b0;
        t_reset();
        t_regs();
        t_cal();
        t_gate();
        t_debounce();
        t_modes();
        give_verdict();
    end
endmodule
`default_nettype wire
